// File: design/vdsc_core.v
`timescale 1ns/1ps
`include "vdsc_defs.vh"
module vdsc_core #(
    parameter FAST_STEP_CYC = `VDSC_FAST_STEP_CYC,
    parameter SLOW_STEP_CYC = `VDSC_SLOW_STEP_CYC,
    parameter SETTLE_CYC = `VDSC_ADC_SETTLE_CYC,
    parameter POWER_ON_CYC = `VDSC_POWER_ON_CYC
) (
    input wire core_clk,
    input wire reset_n,
    input wire clk_en,
    input wire serial_link_clock,
    input wire serial_data_in,
    input wire input_divider_detect,
    input wire supply_detect,
    input wire fault_detect,
    input wire [7:0] adc_result,
    input wire adc_done,
    output reg adc_start,
    output reg [3:0] mux_select,
    output reg [7:0] dac_code,
    output reg [10:0] dac_millivolts,
    output reg rail_enable,
    output reg power_on_ready,
    output reg [2:0] active_phases,
    output reg protect_shutdown,
    output reg [7:0] core_setting_pin_a,
    output reg [7:0] core_setting_pin_b,
    output reg [7:0] core_setting_pin_c,
    output reg [7:0] gfx_setting_pin_a,
    output reg [7:0] gfx_setting_pin_b,
    output reg [7:0] core_current_monitor,
    output reg [7:0] gfx_current_monitor,
    output reg [7:0] core_temp_sense,
    output reg [7:0] gfx_temp_sense,
    output reg settings_valid,
    output reg command_strobe
);
    // ---------------------------------------------------------------
    // sized constants, cut to the width of what they meet
    // ---------------------------------------------------------------
    localparam FRAME_LAST = `VDSC_FRAME_BITS - 1; // index of the last frame bit
    localparam [3:0] LAST_BIT = FRAME_LAST[3:0];
    localparam INPUT_LAST = `VDSC_NUM_INPUTS - 1; // highest mux input
    localparam [3:0] LAST_INPUT = INPUT_LAST[3:0];
    localparam SETTLE_END = SETTLE_CYC - 1; // last settling count
    localparam [4:0] SETTLE_LAST = SETTLE_END[4:0];
    localparam [7:0] PON_LAST = POWER_ON_CYC[7:0]; // qualification length
    localparam [15:0] FAST_STEP = FAST_STEP_CYC[15:0]; // cycles per lsb, fast
    localparam [15:0] SLOW_STEP = SLOW_STEP_CYC[15:0]; // cycles per lsb, slow
    localparam MIN_MV_INT = `VDSC_MIN_MV;
    localparam [10:0] MIN_MV = MIN_MV_INT[10:0]; // millivolts at the lowest code
    localparam STEP_MV_INT = `VDSC_STEP_MV;
    localparam [10:0] STEP_MV = STEP_MV_INT[10:0]; // millivolts per code step
    // ---------------------------------------------------------------
    // pin synchronisers
    // ---------------------------------------------------------------
    reg [1:0] lclk_sync; // serial clock, two stages
    reg [1:0] ldat_sync; // serial data, two stages
    reg [1:0] dvd_sync; // divided input detect
    reg [1:0] vcc_sync; // supply detect
    reg [1:0] flt_sync; // protection event
    reg lclk_prev; // last synced clock level
    // only the second stage feeds logic
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            lclk_sync <= 2'h0;
            ldat_sync <= 2'h0;
            dvd_sync <= 2'h0;
            vcc_sync <= 2'h0;
            flt_sync <= 2'h0;
            lclk_prev <= 1'b0;
        end else if (clk_en) begin
            lclk_sync <= {lclk_sync[0], serial_link_clock};
            ldat_sync <= {ldat_sync[0], serial_data_in};
            dvd_sync <= {dvd_sync[0], input_divider_detect};
            vcc_sync <= {vcc_sync[0], supply_detect};
            flt_sync <= {flt_sync[0], fault_detect};
            lclk_prev <= lclk_sync[1];
        end
    end
    wire lclk_rise = lclk_sync[1] & ~lclk_prev; // data sampled on rising edge
    // ---------------------------------------------------------------
    // serial command receiver
    // ---------------------------------------------------------------
    reg [9:0] shift; // incoming frame bits
    reg [3:0] bit_cnt; // bits in current frame
    reg [7:0] target_code; // commanded voltage code
    reg slow_mode; // selected slew rate
    wire [2:0] phase_req = {shift[1:0], ldat_sync[1]}; // low three code bits
    // framing: fixed 10-bit frames, command then code
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift <= 10'h000;
            bit_cnt <= 4'h0;
            target_code <= `VDSC_CODE_OFF;
            slow_mode <= 1'b0;
            active_phases <= 3'h4;
            command_strobe <= 1'b0;
        end else if (clk_en) begin
            command_strobe <= 1'b0;
            if (lclk_rise) begin
                shift <= {shift[8:0], ldat_sync[1]};
                if (bit_cnt == LAST_BIT) begin
                    bit_cnt <= 4'h0;
                    command_strobe <= 1'b1;
                    case (shift[8:7])
                        `VDSC_CMD_FAST: begin
                            target_code <= {shift[5:0], ldat_sync[1]} == 7'h00 && shift[6] == 1'b0 ?
                                `VDSC_CODE_OFF : {shift[6:0], ldat_sync[1]};
                            slow_mode <= 1'b0;
                        end
                        `VDSC_CMD_SLOW: begin
                            target_code <= {shift[6:0], ldat_sync[1]};
                            slow_mode <= 1'b1;
                        end
                        `VDSC_CMD_PHASES: begin
                            // phase count clamps to 1..4
                            if (phase_req == 3'h0)
                                active_phases <= 3'h1;
                            else if (phase_req > 3'h4)
                                active_phases <= 3'h4;
                            else
                                active_phases <= phase_req;
                        end
                        default: begin
                            target_code <= target_code; // unknown command ignored
                        end
                    endcase
                end else begin
                    bit_cnt <= bit_cnt + 4'h1;
                end
            end
        end
    end
    // ---------------------------------------------------------------
    // power-on sequence and protection
    // ---------------------------------------------------------------
    reg [7:0] pon_cnt; // supplies-good qualification
    wire supplies_good = dvd_sync[1] & vcc_sync[1];
    // ready and shutdown latch
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pon_cnt <= 8'h00;
            power_on_ready <= 1'b0;
            protect_shutdown <= 1'b0;
        end else if (clk_en) begin
            if (!supplies_good) begin
                pon_cnt <= 8'h00;
                power_on_ready <= 1'b0;
                protect_shutdown <= 1'b0; // restart clears latch
            end else if (pon_cnt != PON_LAST) begin
                pon_cnt <= pon_cnt + 8'h01;
            end else begin
                power_on_ready <= 1'b1;
            end
            if (supplies_good && flt_sync[1])
                protect_shutdown <= 1'b1;
        end
    end
    // ---------------------------------------------------------------
    // converter sequencer, nine inputs round robin
    // ---------------------------------------------------------------
    localparam ST_IDLE = 2'h0;
    localparam ST_SETTLE = 2'h1;
    localparam ST_CONV = 2'h2;
    reg [1:0] adc_state; // sequencer state
    reg [4:0] settle_cnt; // mux settling delay
    reg [7:0] result_mem [0:`VDSC_NUM_INPUTS-1]; // per input results
    // select, settle, start, capture
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            adc_state <= ST_IDLE;
            settle_cnt <= 5'h00;
            mux_select <= 4'h0;
            adc_start <= 1'b0;
            settings_valid <= 1'b0;
        end else if (clk_en) begin
            adc_start <= 1'b0;
            case (adc_state)
                ST_IDLE: begin
                    if (power_on_ready) begin
                        settle_cnt <= 5'h00;
                        adc_state <= ST_SETTLE;
                    end
                end
                ST_SETTLE: begin
                    if (settle_cnt == SETTLE_LAST) begin
                        adc_start <= 1'b1;
                        adc_state <= ST_CONV;
                    end else begin
                        settle_cnt <= settle_cnt + 5'h01;
                    end
                end
                ST_CONV: begin
                    if (adc_done) begin
                        if (mux_select == LAST_INPUT) begin
                            mux_select <= 4'h0;
                            settings_valid <= 1'b1;
                        end else begin
                            mux_select <= mux_select + 4'h1;
                        end
                        adc_state <= power_on_ready ? ST_SETTLE : ST_IDLE;
                        settle_cnt <= 5'h00;
                    end
                end
                default: begin
                    adc_state <= ST_IDLE;
                end
            endcase
        end
    end
    // result store, one entry per mux input
    genvar gi;
    generate
        for (gi = 0; gi < `VDSC_NUM_INPUTS; gi = gi + 1) begin : g_store
            always @(posedge core_clk or negedge reset_n) begin
                if (!reset_n)
                    result_mem[gi] <= 8'h00;
                else if (clk_en && adc_state == ST_CONV && adc_done && mux_select == gi)
                    result_mem[gi] <= adc_result;
            end
        end
    endgenerate
    // named result outputs, registered
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            core_setting_pin_a <= 8'h00;
            core_setting_pin_b <= 8'h00;
            core_setting_pin_c <= 8'h00;
            gfx_setting_pin_a <= 8'h00;
            gfx_setting_pin_b <= 8'h00;
            core_current_monitor <= 8'h00;
            gfx_current_monitor <= 8'h00;
            core_temp_sense <= 8'h00;
            gfx_temp_sense <= 8'h00;
        end else if (clk_en) begin
            core_setting_pin_a <= result_mem[0];
            core_setting_pin_b <= result_mem[1];
            core_setting_pin_c <= result_mem[2];
            gfx_setting_pin_a <= result_mem[3];
            gfx_setting_pin_b <= result_mem[4];
            core_current_monitor <= result_mem[5];
            gfx_current_monitor <= result_mem[6];
            core_temp_sense <= result_mem[7];
            gfx_temp_sense <= result_mem[8];
        end
    end
    // ---------------------------------------------------------------
    // slew controller and dac code
    // ---------------------------------------------------------------
    reg [15:0] slew_cnt; // cycles since last step
    wire [15:0] step_cyc = slow_mode ? SLOW_STEP : FAST_STEP;
    wire run = power_on_ready & ~protect_shutdown;
    wire [7:0] goal = run ? target_code : `VDSC_CODE_OFF;
    wire [10:0] code_steps = {3'h0, dac_code - 8'h01}; // steps above the lowest code
    // one lsb per interval toward goal
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            slew_cnt <= 16'h0000;
            dac_code <= `VDSC_CODE_OFF;
        end else if (clk_en) begin
            if (dac_code == goal) begin
                slew_cnt <= 16'h0000;
            end else if (slew_cnt >= step_cyc - 16'h0001) begin
                slew_cnt <= 16'h0000;
                if (dac_code < goal)
                    dac_code <= dac_code + 8'h01;
                else
                    dac_code <= dac_code - 8'h01;
            end else begin
                slew_cnt <= slew_cnt + 16'h0001;
            end
        end
    end
    // voltage follows the dac code, rail state the code and run
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            dac_millivolts <= 11'h000;
            rail_enable <= 1'b0;
        end else if (clk_en) begin
            if (dac_code == `VDSC_CODE_OFF) begin
                dac_millivolts <= 11'h000;
                rail_enable <= 1'b0;
            end else begin
                dac_millivolts <= MIN_MV + code_steps * STEP_MV;
                rail_enable <= run;
            end
        end
    end
endmodule

// File: design/vdsc_defs.vh
`ifndef VDSC_DEFS_VH
`define VDSC_DEFS_VH
// ---------------------------------------------------------------
// voltage code and slew timing
// ---------------------------------------------------------------
`define VDSC_CLK_MHZ 200
`define VDSC_STEP_UV 5000
`define VDSC_FAST_SLEW_UV_PER_US_X100 1125000
`define VDSC_SLOW_SLEW_UV_PER_US_X1000 5625000
// cycles per 5 mV step: 5000uV / (11.25 mV/us) * 200 MHz, rounded down
`define VDSC_FAST_STEP_CYC ((`VDSC_STEP_UV * `VDSC_CLK_MHZ * 100) / `VDSC_FAST_SLEW_UV_PER_US_X100)
`define VDSC_SLOW_STEP_CYC ((`VDSC_STEP_UV * `VDSC_CLK_MHZ * 1000) / `VDSC_SLOW_SLEW_UV_PER_US_X1000)
`define VDSC_CODE_OFF 8'h00
`define VDSC_CODE_MIN 8'h01
`define VDSC_CODE_MAX 8'hff
`define VDSC_MIN_MV 250
`define VDSC_STEP_MV 5
// ---------------------------------------------------------------
// serial frame: 2 command bits then 8 code bits, msb first
// ---------------------------------------------------------------
`define VDSC_FRAME_BITS 10
`define VDSC_CMD_FAST 2'b01
`define VDSC_CMD_SLOW 2'b10
`define VDSC_CMD_PHASES 2'b11
// ---------------------------------------------------------------
// converter input selection
// ---------------------------------------------------------------
`define VDSC_NUM_INPUTS 9
`define VDSC_ADC_SETTLE_CYC 16
`define VDSC_POWER_ON_CYC 32
`endif

// File: test/vdsc_chk.sv
`timescale 1ns/1ps
module vdsc_chk #(
    parameter FAST_STEP_CYC = 88,
    parameter SLOW_STEP_CYC = 177
) (
    input wire core_clk,
    input wire reset_n,
    input wire clk_en,
    input wire input_divider_detect,
    input wire supply_detect,
    input wire adc_start,
    input wire [3:0] mux_select,
    input wire [7:0] dac_code,
    input wire [10:0] dac_millivolts,
    input wire power_on_ready,
    input wire [2:0] active_phases,
    input wire protect_shutdown,
    input wire command_strobe
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    // ----------------------------------------
    // cycles since the last code move
    // ----------------------------------------
    reg [15:0] gap; // restarted by a move or a command
    reg stepping; // a move seen since the last command
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            gap <= 16'h0000;
            stepping <= 1'b0;
        end else begin
            gap <= (command_strobe || $changed(dac_code)) ? 16'h0000 : gap + 16'h0001;
            // a new goal without a command restarts the interval unseen, and a freeze holds slew_cnt while gap runs on
            stepping <= clk_en && !command_strobe && !$rose(protect_shutdown) && !$fell(power_on_ready) &&
                (stepping || $changed(dac_code));
        end
    end
    sequence s_step;
        $changed(dac_code) && dac_code != 8'h00 && $past(dac_code) != 8'h00;
    endsequence
    sequence s_idle3;
        !power_on_ready [*3];
    endsequence
    a_step_one_lsb: assert property (s_step |->
        dac_code == $past(dac_code) + 8'h01 || dac_code == $past(dac_code) - 8'h01)
        else $error("code moved by more than one step");
    a_step_period: assert property (s_step ##0 stepping |->
        gap == FAST_STEP_CYC - 1 || gap == SLOW_STEP_CYC - 1) else $error("step spacing wrong");
    a_mv_decode: assert property (dac_millivolts ==
        ($past(dac_code) == 8'h00 ? 11'h000 : 11'h0f5 + 11'h005 * $past(dac_code))) else $error("millivolts wrong");
    a_mux_round: assert property ($changed(mux_select) |->
        mux_select == ($past(mux_select) == 4'h8 ? 4'h0 : $past(mux_select) + 4'h1)) else $error("mux order");
    a_mux_range: assert property (mux_select <= 4'h8) else $error("mux out of range");
    a_start_pulse: assert property (adc_start && clk_en |=> !adc_start) else $error("start too long");
    a_strobe_pulse: assert property (command_strobe && clk_en |=> !command_strobe) else $error("strobe long");
    a_ready_cause: assert property ($rose(power_on_ready) |->
        $past(input_divider_detect && supply_detect, 3)) else $error("ready without good inputs");
    a_ready_drop: assert property ($fell(supply_detect) |-> ##[1:5] !power_on_ready) else $error("ready held");
    a_idle_zero: assert property (s_idle3 |-> dac_code <= $past(dac_code))
        else $error("code rose while not ready");
    a_fault_zero: assert property (protect_shutdown [*2] |-> dac_code <= $past(dac_code))
        else $error("code rose in fault");
    a_phase_range: assert property (active_phases >= 3'h1 && active_phases <= 3'h4)
        else $error("phase count out of range");
endmodule
bind vdsc_core vdsc_chk #(.FAST_STEP_CYC(FAST_STEP_CYC), .SLOW_STEP_CYC(SLOW_STEP_CYC)) chk (.core_clk, .reset_n, .clk_en,
    .input_divider_detect, .supply_detect, .adc_start, .mux_select, .dac_code, .dac_millivolts,
    .power_on_ready, .active_phases, .protect_shutdown, .command_strobe);

// File: test/vdsc_core_bench.sv
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %s expected %0h seen %0h", nm, e, g); end end
`define WAITC(c, n, nm) begin for (int k = 0; k < n && (c) !== 1'b1; k++) tick(1); \
    if ((c) !== 1'b1) begin err_count++; $display("BAD %s expected 1 seen timeout", nm); end_of_test; end end
module vdsc_core_bench;
    localparam int FAST = 5000 * 200 * 100 / 1125000; // 5 mV at 11.25 mV/us
    localparam int SLOW = 5000 * 200 * 1000 / 5625000; // 5 mV at 5.625 mV/us
    logic core_clk, reset_n, clk_en, input_divider_detect, supply_detect, fault_detect, adc_done;
    logic [7:0] adc_result;
    wire serial_link_clock, serial_data_in, adc_start, rail_enable, power_on_ready;
    wire protect_shutdown, settings_valid, command_strobe;
    wire [3:0] mux_select;
    wire [7:0] dac_code;
    wire [10:0] dac_millivolts;
    wire [2:0] active_phases;
    wire [7:0] res [0:8];
    logic [7:0] exp_res [0:8]; // fixed level on each converter input
    logic [31:0] rng = 32'h0000e74c; // seed 59212
    int err_count, samples_checked;
    vdsc_core #(.SETTLE_CYC(2), .POWER_ON_CYC(2)) DUT (.core_clk, .reset_n, .clk_en, .serial_link_clock,
        .serial_data_in, .input_divider_detect, .supply_detect, .fault_detect, .adc_result, .adc_done,
        .adc_start, .mux_select, .dac_code, .dac_millivolts, .rail_enable, .power_on_ready, .active_phases,
        .protect_shutdown, .core_setting_pin_a(res[0]), .core_setting_pin_b(res[1]),
        .core_setting_pin_c(res[2]), .gfx_setting_pin_a(res[3]), .gfx_setting_pin_b(res[4]),
        .core_current_monitor(res[5]), .gfx_current_monitor(res[6]), .core_temp_sense(res[7]),
        .gfx_temp_sense(res[8]), .settings_valid, .command_strobe);
    vdsc_cpu_model cpu (.serial_link_clock, .serial_data_in);
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    function automatic int mv(input int c);
        return (c == 0) ? 0 : 250 + 5 * (c - 1);
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // ramp to a target, timing one whole step on the way
    task automatic ramp(input logic [1:0] cmd, input logic [7:0] code, input int per);
        logic [7:0] was;
        int n;
        cpu.send(cmd, code);
        was = dac_code;
        `WAITC(dac_code !== was, 400, "first step")
        was = dac_code;
        for (n = 0; dac_code === was && n < per + 9; n++) tick(1);
        `CHECK("step period", per, n)
        `WAITC(dac_code === code, 300 * per, "target")
        tick(2);
        `CHECK("millivolts", mv(code), dac_millivolts)
    endtask
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    // converter stand-in: answers each start with that input's level
    initial begin
        adc_done = 1'b0;
        adc_result = 8'h00;
        forever begin
            tick(1);
            if (adc_start === 1'b1) begin
                adc_result = exp_res[mux_select];
                tick(1);
                adc_done = 1'b1;
                tick(1);
                adc_done = 1'b0;
            end
        end
    end
    initial begin
        reset_n = 1'b0;
        clk_en = 1'b1;
        input_divider_detect = 1'b0;
        supply_detect = 1'b0;
        fault_detect = 1'b0;
        for (int i = 0; i < 9; i++) begin
            rng = xs(rng);
            exp_res[i] = rng[7:0];
        end
        tick(6);
        reset_n = 1'b1;
        `CHECK("reset", {8'h00, 3'h4, 1'b0}, {dac_code, active_phases, power_on_ready})
        supply_detect = 1'b1;
        tick(40);
        `CHECK("ready early", 1'b0, power_on_ready)
        input_divider_detect = 1'b1;
        `WAITC(power_on_ready, 20, "ready")
        `WAITC(settings_valid, 3000, "sweep")
        tick(3);
        for (int i = 0; i < 9; i++) `CHECK("setting", exp_res[i], res[i])
        ramp(2'b01, 8'h06, FAST);
        ramp(2'b10, 8'h02, SLOW);
        ramp(2'b01, 8'hff, FAST);
        for (int p = 1; p <= 4; p++) begin
            cpu.send(2'b11, 8'(p));
            tick(10);
            `CHECK("phases", 3'(p), active_phases)
        end
        cpu.send(2'b00, 8'h10);
        tick(10);
        `CHECK("refused", 8'hff, dac_code)
        `CHECK("rail on", 1'b1, rail_enable)
        cpu.send(2'b01, 8'h00);
        `WAITC(rail_enable === 1'b0, 256 * FAST + 20, "rail off")
        `CHECK("rail off code", 8'h00, dac_code)
        ramp(2'b01, 8'h06, FAST);
        fault_detect = 1'b1;
        `WAITC(protect_shutdown, 20, "shutdown")
        fault_detect = 1'b0;
        clk_en = 1'b0; // freeze all state with the code still up
        tick(200);
        `CHECK("frozen", {1'b1, 8'h06}, {protect_shutdown, dac_code})
        clk_en = 1'b1;
        `WAITC(dac_code === 8'h00, 7 * FAST, "shutdown ramp")
        tick(2);
        `CHECK("latched", {1'b1, 1'b0, 11'h000}, {protect_shutdown, rail_enable, dac_millivolts})
        supply_detect = 1'b0;
        `WAITC(power_on_ready === 1'b0, 20, "ready drop")
        reset_n = 1'b0; // second reset in mid-run
        tick(2);
        reset_n = 1'b1;
        `CHECK("reset again", {1'b0, 8'h00, 1'b0}, {settings_valid, res[0], protect_shutdown})
        end_of_test;
    end
endmodule

// File: test/vdsc_cpu_model.sv
`timescale 1ns/1ps
module vdsc_cpu_model (
    output logic serial_link_clock,
    output logic serial_data_in
);
    // link clock parked low between frames
    initial begin
        serial_link_clock = 1'b0;
        serial_data_in = 1'b0;
    end
    // one frame, msb first, 80 ns link clock
    task automatic send(input logic [1:0] cmd, input logic [7:0] code);
        logic [9:0] frame;
        frame = {cmd, code};
        for (int i = 9; i >= 0; i--) begin
            serial_data_in = frame[i];
            #40 serial_link_clock = 1'b1;
            #40 serial_link_clock = 1'b0;
        end
        serial_data_in = ~frame[0]; // no stale bit once released
    endtask
endmodule
